// *** inc/usbief_map.vh ***
// Register offsets, field positions and reset values of the USB interrupt enable/force block
`ifndef USBIEF_MAP_VH
`define USBIEF_MAP_VH
`define USBIEF_OFF_RAW 12'h08c
`define USBIEF_OFF_ENABLE 12'h090
`define USBIEF_OFF_FORCE 12'h094
`define USBIEF_OFF_MASKED 12'h098
`define USBIEF_OFF_ENG_STATUS 12'h050
`define USBIEF_OFF_FRAME_RD 12'h054
`define USBIEF_OFF_HALT_FLAGS 12'h058
`define USBIEF_OFF_ABORT_FLAGS 12'h05c
`define USBIEF_OFF_BUF_FLAGS 12'h060
`define USBIEF_OFF_ROLE 12'h040
`define USBIEF_SRC_W 20
`define USBIEF_SRC_RESET 20'h00000
`define USBIEF_BIT_HALT 19
`define USBIEF_BIT_ABORT 18
`define USBIEF_BIT_DEVICE_FRAME_START_SEEN 17
`define USBIEF_BIT_SETUP 16
`define USBIEF_BIT_DEV_WAKE 15
`define USBIEF_BIT_SLEEP 14
`define USBIEF_BIT_ATTACH 13
`define USBIEF_BIT_BUS_RESET 12
`define USBIEF_BIT_DATA_SEQ 5
`define USBIEF_BIT_BUF 4
`define USBIEF_BIT_XFER 3
`define USBIEF_BIT_HOST_SOF 2
`define USBIEF_BIT_HOST_WAKE 1
`define USBIEF_BIT_DOWN_ATTACH 0
`define USBIEF_ES_SPEED_LO 0
`define USBIEF_ES_SPEED_HI 1
`define USBIEF_ES_SLEEP 4
`define USBIEF_ES_ATTACH 16
`define USBIEF_ES_XFER 18
`define USBIEF_ES_WAKE 11
`define USBIEF_ES_ERR_LO 23
`define USBIEF_ES_W 32
`endif

// *** hw/usbief_sticky.v ***
// Bank of sticky flags: set by hardware events, cleared by per-bit strobes
`timescale 1ns/1ps
`default_nettype none
module usbief_sticky #(
    parameter WIDTH = 8
) (
    input wire clk_in, // System clock
    input wire rst_in, // Synchronous reset, active high
    input wire [WIDTH-1:0] set_in, // One-cycle set events
    input wire [WIDTH-1:0] clear_in, // One-cycle clear strobes
    output reg [WIDTH-1:0] flag_out // Held flags
);
    // Set wins over a clear in the same cycle
    always @(posedge clk_in) begin
        if (rst_in) begin
            flag_out <= {WIDTH{1'b0}};
        end else begin
            flag_out <= (flag_out & ~clear_in) | set_in;
        end
    end
endmodule // usbief_sticky
`default_nettype wire

// *** hw/usbief_sync.v ***
// Two-stage synchroniser for a bus of pin-level inputs
`timescale 1ns/1ps
`default_nettype none
module usbief_sync #(
    parameter WIDTH = 1
) (
    input wire clk_in, // System clock
    input wire rst_in, // Synchronous reset, active high
    input wire [WIDTH-1:0] async_in, // Inputs from another domain
    output reg [WIDTH-1:0] sync_out // Synchronised copy
);
    reg [WIDTH-1:0] stage_one;
    // First stage feeds only the second
    always @(posedge clk_in) begin
        if (rst_in) begin
            stage_one <= {WIDTH{1'b0}};
            sync_out <= {WIDTH{1'b0}};
        end else begin
            stage_one <= async_in;
            sync_out <= stage_one;
        end
    end
endmodule // usbief_sync
`default_nettype wire

// *** hw/usbief_top.v ***
// USB interrupt enable/force block with raw, masked and engine status registers on APB
`timescale 1ns/1ps
`default_nettype none
`include "usbief_map.vh"
module usbief_top #(
    parameter NUM_EP = 32, // Endpoint flag bits per summary register
    parameter FRAME_W = 11 // Frame number width
) (
    input wire clk_in, // System clock, 100 MHz
    input wire rst_in, // Synchronous reset, active high
    input wire psel_in, // APB select
    input wire penable_in, // APB enable
    input wire pwrite_in, // APB direction
    input wire [11:0] paddr_in, // APB byte address
    input wire [31:0] pwdata_in, // APB write data
    output reg [31:0] prdata_out, // APB read data
    output reg pready_out, // APB ready
    output reg pslverr_out, // APB error on unmapped address
    input wire frame_seen_in, // Pulse: frame start received (device role)
    input wire frame_sent_in, // Pulse: frame start sent (host role)
    input wire [FRAME_W-1:0] frame_num_in, // Current frame number
    input wire wake_in, // Level: resume signalling seen
    input wire sleep_in, // Level: device suspended
    input wire attach_in, // Level: device connected
    input wire [1:0] speed_in, // Level: attached device speed (host role)
    input wire xfer_done_in, // Pulse: transfer finished
    input wire [8:0] err_in, // Pulses: setup, bus reset, supply, stall, crc, stuff, ovf, tmo, seq
    input wire [NUM_EP-1:0] halt_set_in, // Pulses: per-endpoint halt/refuse events
    input wire [NUM_EP-1:0] abort_set_in, // Pulses: per-endpoint abort done
    input wire [NUM_EP-1:0] buf_set_in, // Pulses: per-endpoint buffer done
    output reg irq_out // Level interrupt to the processor
);
    wire [NUM_EP-1:0] halt_flags;
    wire [NUM_EP-1:0] abort_flags;
    wire [NUM_EP-1:0] buf_flags;
    wire [2:0] lvl_sync;
    wire [1:0] speed_sync;
    wire [8:0] err_flags;
    wire [4:0] evt_flags;
    reg host_role;
    reg [`USBIEF_SRC_W-1:0] enable_mask;
    reg [`USBIEF_SRC_W-1:0] force_set;
    reg [2:0] lvl_prev;
    reg [1:0] speed_prev;
    reg [FRAME_W-1:0] frame_num;
    reg device_frame_start_seen;
    reg host_sof;
    reg [`USBIEF_SRC_W-1:0] raw_view;
    reg [`USBIEF_SRC_W-1:0] masked_view;
    reg [31:0] next_rdata;
    reg next_err;

    // True when an APB access is in its access phase
    wire acc = psel_in & penable_in & ~pready_out;
    wire wr = acc & pwrite_in;
    wire rd = acc & ~pwrite_in;

    // Write strobe per register; returns per-bit write-one clear mask
    function [31:0] w1c;
        input hit;
        input [31:0] data;
        begin
            w1c = hit ? data : 32'h00000000;
        end
    endfunction

    wire hit_es = (paddr_in == `USBIEF_OFF_ENG_STATUS);
    wire [31:0] es_clr = w1c(wr & hit_es, pwdata_in);
    wire [31:0] raw_clr = w1c(wr & (paddr_in == `USBIEF_OFF_RAW), pwdata_in);
    wire frame_rd = rd & (paddr_in == `USBIEF_OFF_FRAME_RD);

    // Pin-level inputs: wake, sleep, attach, speed
    usbief_sync #(.WIDTH(3)) u_lvl_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in({wake_in, sleep_in, attach_in}),
        .sync_out(lvl_sync)
    );
    usbief_sync #(.WIDTH(2)) u_spd_sync (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .async_in(speed_in),
        .sync_out(speed_sync)
    );

    // Edge history for the level sources
    always @(posedge clk_in) begin
        if (rst_in) begin
            lvl_prev <= 3'h0;
            speed_prev <= 2'h0;
        end else begin
            lvl_prev <= lvl_sync;
            speed_prev <= speed_sync;
        end
    end

    // Per-endpoint flag banks, write one to clear
    usbief_sticky #(.WIDTH(NUM_EP)) u_halt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in(halt_set_in),
        .clear_in(w1c(wr & (paddr_in == `USBIEF_OFF_HALT_FLAGS), pwdata_in)),
        .flag_out(halt_flags)
    );
    usbief_sticky #(.WIDTH(NUM_EP)) u_abort (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in(abort_set_in),
        .clear_in(w1c(wr & (paddr_in == `USBIEF_OFF_ABORT_FLAGS), pwdata_in)),
        .flag_out(abort_flags)
    );
    usbief_sticky #(.WIDTH(NUM_EP)) u_buf (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in(buf_set_in),
        .clear_in(w1c(wr & (paddr_in == `USBIEF_OFF_BUF_FLAGS), pwdata_in)),
        .flag_out(buf_flags)
    );

    // Engine status error flags, cleared by writing ones at the engine status bits
    usbief_sticky #(.WIDTH(9)) u_err (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in(err_in),
        .clear_in(es_clr[`USBIEF_ES_ERR_LO+8:`USBIEF_ES_ERR_LO]),
        .flag_out(err_flags)
    );

    // Event flags: xfer(3) host wake(2) dev wake(1) sleep chg(0)... attach chg(4)
    usbief_sticky #(.WIDTH(5)) u_evt (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .set_in({
            lvl_sync[0] ^ lvl_prev[0],
            xfer_done_in,
            lvl_sync[2] & ~lvl_prev[2] & host_role,
            lvl_sync[2] & ~lvl_prev[2] & ~host_role,
            lvl_sync[1] ^ lvl_prev[1]
        }),
        .clear_in({
            es_clr[`USBIEF_ES_ATTACH],
            raw_clr[`USBIEF_BIT_XFER],
            es_clr[`USBIEF_ES_WAKE],
            es_clr[`USBIEF_ES_WAKE],
            es_clr[`USBIEF_ES_SLEEP]
        }),
        .flag_out(evt_flags)
    );

    // Host downstream attach change on speed field change
    reg down_attach;
    always @(posedge clk_in) begin
        if (rst_in) begin
            down_attach <= 1'b0;
        end else if (host_role & (speed_sync != speed_prev)) begin
            down_attach <= 1'b1;
        end else if (|es_clr[`USBIEF_ES_SPEED_HI:`USBIEF_ES_SPEED_LO]) begin
            down_attach <= 1'b0;
        end
    end

    // Frame start flags, cleared by reading the frame-number register
    always @(posedge clk_in) begin
        if (rst_in) begin
            device_frame_start_seen <= 1'b0;
            host_sof <= 1'b0;
            frame_num <= {FRAME_W{1'b0}};
        end else begin
            frame_num <= frame_num_in;
            if (frame_seen_in & ~host_role) begin
                device_frame_start_seen <= 1'b1;
            end else if (frame_rd) begin
                device_frame_start_seen <= 1'b0;
            end
            if (frame_sent_in & host_role) begin
                host_sof <= 1'b1;
            end else if (frame_rd) begin
                host_sof <= 1'b0;
            end
        end
    end

    // Raw interrupt view assembly
    always @* begin
        raw_view = `USBIEF_SRC_RESET;
        raw_view[`USBIEF_BIT_HALT] = |halt_flags;
        raw_view[`USBIEF_BIT_ABORT] = |abort_flags;
        raw_view[`USBIEF_BIT_DEVICE_FRAME_START_SEEN] = device_frame_start_seen;
        raw_view[`USBIEF_BIT_SETUP] = err_flags[8];
        raw_view[`USBIEF_BIT_DEV_WAKE] = evt_flags[1];
        raw_view[`USBIEF_BIT_SLEEP] = evt_flags[0];
        raw_view[`USBIEF_BIT_ATTACH] = evt_flags[4];
        raw_view[`USBIEF_BIT_BUS_RESET:`USBIEF_BIT_DATA_SEQ] = err_flags[7:0];
        raw_view[`USBIEF_BIT_BUF] = |buf_flags;
        raw_view[`USBIEF_BIT_XFER] = evt_flags[3];
        raw_view[`USBIEF_BIT_HOST_SOF] = host_sof;
        raw_view[`USBIEF_BIT_HOST_WAKE] = evt_flags[2];
        raw_view[`USBIEF_BIT_DOWN_ATTACH] = down_attach;
        masked_view = (raw_view | force_set) & enable_mask;
    end

    // Read mux with decode of mapped addresses
    always @* begin
        next_rdata = 32'h00000000;
        next_err = 1'b0;
        if (paddr_in == `USBIEF_OFF_RAW) begin
            next_rdata[`USBIEF_SRC_W-1:0] = raw_view;
        end else if (paddr_in == `USBIEF_OFF_ENABLE) begin
            next_rdata[`USBIEF_SRC_W-1:0] = enable_mask;
        end else if (paddr_in == `USBIEF_OFF_FORCE) begin
            next_rdata[`USBIEF_SRC_W-1:0] = force_set;
        end else if (paddr_in == `USBIEF_OFF_MASKED) begin
            next_rdata[`USBIEF_SRC_W-1:0] = masked_view;
        end else if (hit_es) begin
            next_rdata[`USBIEF_ES_SPEED_HI:`USBIEF_ES_SPEED_LO] = speed_sync;
            next_rdata[`USBIEF_ES_SLEEP] = lvl_sync[1];
            next_rdata[`USBIEF_ES_WAKE] = evt_flags[1] | evt_flags[2];
            next_rdata[`USBIEF_ES_ATTACH] = lvl_sync[0];
            next_rdata[`USBIEF_ES_XFER] = evt_flags[3];
            next_rdata[`USBIEF_ES_ERR_LO+8:`USBIEF_ES_ERR_LO] = err_flags;
        end else if (paddr_in == `USBIEF_OFF_FRAME_RD) begin
            next_rdata[FRAME_W-1:0] = frame_num;
        end else if (paddr_in == `USBIEF_OFF_HALT_FLAGS) begin
            next_rdata[NUM_EP-1:0] = halt_flags;
        end else if (paddr_in == `USBIEF_OFF_ABORT_FLAGS) begin
            next_rdata[NUM_EP-1:0] = abort_flags;
        end else if (paddr_in == `USBIEF_OFF_BUF_FLAGS) begin
            next_rdata[NUM_EP-1:0] = buf_flags;
        end else if (paddr_in == `USBIEF_OFF_ROLE) begin
            next_rdata[0] = host_role;
        end else begin
            next_err = 1'b1;
        end
    end

    // APB slave: one wait state, writes to control registers
    always @(posedge clk_in) begin
        if (rst_in) begin
            pready_out <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out <= 32'h00000000;
            enable_mask <= `USBIEF_SRC_RESET;
            force_set <= `USBIEF_SRC_RESET;
            host_role <= 1'b0;
        end else begin
            pready_out <= acc;
            pslverr_out <= acc & next_err;
            prdata_out <= rd ? next_rdata : 32'h00000000;
            if (wr & (paddr_in == `USBIEF_OFF_ENABLE)) begin
                enable_mask <= pwdata_in[`USBIEF_SRC_W-1:0];
            end
            if (wr & (paddr_in == `USBIEF_OFF_FORCE)) begin
                force_set <= pwdata_in[`USBIEF_SRC_W-1:0];
            end
            if (wr & (paddr_in == `USBIEF_OFF_ROLE)) begin
                host_role <= pwdata_in[0];
            end
        end
    end

    // Interrupt line from masked view
    always @(posedge clk_in) begin
        if (rst_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |masked_view;
        end
    end
endmodule // usbief_top
`default_nettype wire

// *** tb/usbief_top_asserts.sv ***
// Port assertions for the USB interrupt enable/force block
`timescale 1ns/1ps
`default_nettype none
`include "usbief_map.vh"
module usbief_checker #(
    parameter NUM_EP = 32
) (
    input wire logic clk_in, // Clock
    input wire logic rst_in, // Reset
    input wire logic psel_in, // Select
    input wire logic penable_in, // Enable
    input wire logic pwrite_in, // Write
    input wire logic [11:0] paddr_in, // Address
    input wire logic [31:0] pwdata_in, // Write data
    input wire logic [31:0] prdata_out, // Read data
    input wire logic pready_out, // Ready
    input wire logic pslverr_out, // Error
    input wire logic xfer_done_in, // Transfer done
    input wire logic [8:0] err_in, // Error pulses
    input wire logic [NUM_EP-1:0] halt_set_in, // Halt pulses
    input wire logic irq_out // Interrupt
);
    logic [19:0] en_sh;
    logic [19:0] fo_sh;
    wire wr = psel_in && penable_in && !pready_out && pwrite_in;
    wire rd = pready_out && !pwrite_in;
    // Shadow copies of enable and force as written over the bus
    always @(posedge clk_in) begin
        if (rst_in) begin
            en_sh <= 20'h00000;
            fo_sh <= 20'h00000;
        end else if (wr) begin
            en_sh <= (paddr_in == `USBIEF_OFF_ENABLE) ? pwdata_in[19:0] : en_sh;
            fo_sh <= (paddr_in == `USBIEF_OFF_FORCE) ? pwdata_in[19:0] : fo_sh;
        end
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_READY_LAT: assert property (psel_in && penable_in && !pready_out |=> pready_out)
        else $error("ready not one cycle after access");
    AST_READY_ONE: assert property (pready_out |=> !pready_out)
        else $error("ready held two cycles");
    AST_ERR_PAIR: assert property (pslverr_out |-> pready_out)
        else $error("error without ready");
    AST_EN_READ: assert property (rd && paddr_in == `USBIEF_OFF_ENABLE |->
        prdata_out == {12'h000, en_sh} && !pslverr_out) else $error("enable readback wrong");
    AST_FO_READ: assert property (rd && paddr_in == `USBIEF_OFF_FORCE |->
        prdata_out == {12'h000, fo_sh} && !pslverr_out) else $error("force readback wrong");
    AST_NO_EN: assert property (en_sh == 20'h00000 && $past(en_sh) == 20'h00000 |-> !irq_out)
        else $error("interrupt with nothing enabled");
    AST_FORCE: assert property (|(en_sh & fo_sh) |=> irq_out)
        else $error("enabled force gave no interrupt");
    AST_XFER: assert property (xfer_done_in && en_sh[3] |-> ##[1:3] irq_out)
        else $error("transfer end gave no interrupt");
    AST_ERR: assert property (|(err_in & {en_sh[16], en_sh[12:5]}) |-> ##[1:3] irq_out)
        else $error("engine flag gave no interrupt");
    AST_HALT: assert property (|halt_set_in && en_sh[19] |-> ##[1:3] irq_out)
        else $error("endpoint halt gave no interrupt");
    // Main scenarios reached
    cover property (pslverr_out);
    cover property (|(en_sh & fo_sh) && irq_out);
    cover property ($fell(irq_out));
endmodule // usbief_checker
bind usbief_top usbief_checker #(.NUM_EP(NUM_EP)) u_chk (.clk_in(clk_in), .rst_in(rst_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .xfer_done_in(xfer_done_in), .err_in(err_in),
    .halt_set_in(halt_set_in), .irq_out(irq_out));
`default_nettype wire

// *** tb/usbief_engine_model.sv ***
// Behavioural engine status logic feeding the interrupt block
`timescale 1ns/1ps
`default_nettype none
module usbief_engine_model #(
    parameter NUM_EP = 32
) (
    input wire logic clk_in, // Clock
    input wire logic go_in, // Fire one event
    input wire logic [4:0] ev_in, // Event code
    input wire logic [4:0] idx_in, // Endpoint index
    output logic frame_seen_out, // Frame start received
    output logic frame_sent_out, // Frame start sent
    output logic wake_out, // Resume level
    output logic sleep_out, // Suspend level
    output logic attach_out, // Connect level
    output logic [1:0] speed_out, // Speed field
    output logic xfer_done_out, // Transfer finished
    output logic [8:0] err_out, // Engine flag pulses
    output logic [NUM_EP-1:0] halt_out, // Halt pulses
    output logic [NUM_EP-1:0] abort_out, // Abort pulses
    output logic [NUM_EP-1:0] buf_out // Buffer pulses
);
    logic [2:0] wake_cnt = 3'h0;
    // Quiet lines at start
    initial begin
        {frame_seen_out, frame_sent_out, wake_out, sleep_out, attach_out} = 5'h00;
        {speed_out, xfer_done_out, err_out, halt_out, abort_out, buf_out} = '0;
    end
    // Pulses last one cycle, resume level holds long enough to cross the synchroniser
    always @(posedge clk_in) begin
        {frame_seen_out, frame_sent_out, xfer_done_out} <= 3'h0;
        {err_out, halt_out, abort_out, buf_out} <= '0;
        wake_cnt <= (wake_cnt != 3'h0) ? wake_cnt - 3'h1 : 3'h0;
        wake_out <= (wake_cnt != 3'h0);
        if (go_in) begin
            case (ev_in)
                5'd0: frame_seen_out <= 1'b1;
                5'd1: frame_sent_out <= 1'b1;
                5'd2: wake_cnt <= 3'h5;
                5'd3: sleep_out <= !sleep_out;
                5'd4: attach_out <= !attach_out;
                5'd5: speed_out <= speed_out + 2'h1;
                5'd6: xfer_done_out <= 1'b1;
                5'd16: halt_out[idx_in] <= 1'b1;
                5'd17: abort_out[idx_in] <= 1'b1;
                5'd18: buf_out[idx_in] <= 1'b1;
                default: err_out[ev_in - 5'd7] <= 1'b1;
            endcase
        end
    end
endmodule // usbief_engine_model
`default_nettype wire

// *** tb/usbief_top_test.sv ***
// Self-checking bench for the USB interrupt enable/force block
`timescale 1ns/1ps
`default_nettype none
`include "usbief_map.vh"
module usbief_top_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic psel = 1'b0;
    logic pen = 1'b0;
    logic pwr = 1'b0;
    logic [11:0] pad = 12'h000;
    logic [31:0] pwd = 32'h00000000;
    logic go = 1'b0;
    logic [4:0] ev = 5'h00;
    logic [4:0] idx = 5'h00;
    logic [31:0] q;
    logic e;
    int errors = 0;
    int checks = 0;
    wire [31:0] prd;
    wire rdy, slv, irq, fs, fx, wk, sl, at, xd;
    wire [1:0] sp;
    wire [8:0] er;
    wire [31:0] ht, ab, bf;
    // Free-running clock
    always #5 clk_in = !clk_in;
    usbief_top #(.NUM_EP(32), .FRAME_W(11)) dut (.clk_in(clk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(pad), .pwdata_in(pwd),
        .prdata_out(prd), .pready_out(rdy), .pslverr_out(slv), .frame_seen_in(fs),
        .frame_sent_in(fx), .frame_num_in(11'h000), .wake_in(wk), .sleep_in(sl),
        .attach_in(at), .speed_in(sp), .xfer_done_in(xd), .err_in(er), .halt_set_in(ht),
        .abort_set_in(ab), .buf_set_in(bf), .irq_out(irq));
    usbief_engine_model #(.NUM_EP(32)) eng (.clk_in(clk_in), .go_in(go), .ev_in(ev),
        .idx_in(idx), .frame_seen_out(fs), .frame_sent_out(fx), .wake_out(wk),
        .sleep_out(sl), .attach_out(at), .speed_out(sp), .xfer_done_out(xd), .err_out(er),
        .halt_out(ht), .abort_out(ab), .buf_out(bf));
    // Compare and count
    task chk(input logic [31:0] s, input logic [31:0] x);
        checks++;
        if (s !== x) begin
            errors++;
            $display("MISMATCH %0t seen %h expected %h", $time, s, x);
        end
    endtask
    task results;
        if (errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // One bus transfer: setup, access held until ready
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        {psel, pen, pwr, pad, pwd} <= {1'b1, 1'b0, w, a, d};
        @(posedge clk_in);
        pen <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (rdy !== 1'b1 && n < 20);
        q = prd;
        e = slv;
        if (rdy !== 1'b1) begin
            errors++;
            results();
        end
        {psel, pen} <= 2'b00;
        @(posedge clk_in);
    endtask
    // Fire one engine event, then let it settle
    task fire(input logic [4:0] c, input logic [4:0] i);
        {go, ev, idx} <= {1'b1, c, i};
        @(posedge clk_in);
        go <= 1'b0;
        repeat (8) @(posedge clk_in);
    endtask
    // Raise a source, see its raw bit, clear it and see it drop
    task ev_chk(input logic h, input logic [4:0] c, input int b, input logic [11:0] ca,
            input logic [31:0] cd);
        apb(1'b1, `USBIEF_OFF_ROLE, {31'h0, h});
        fire(c, 5'h00);
        apb(1'b0, `USBIEF_OFF_RAW, 32'h0);
        chk(32'(q[b]), 32'h1);
        if (ca == `USBIEF_OFF_FRAME_RD) begin
            apb(1'b0, ca, 32'h0);
        end else if (ca != 12'h000) begin
            apb(1'b1, ca, cd);
        end
        apb(1'b0, `USBIEF_OFF_RAW, 32'h0);
        chk(32'(q[b]), (ca == 12'h000) ? 32'h1 : 32'h0);
    endtask
    // Two endpoints flagged; summary holds until both are cleared
    task ep_chk(input logic [4:0] c, input int b, input logic [11:0] fa);
        logic [4:0] i;
        i = 5'($urandom_range(30));
        fire(c, i);
        fire(c, i + 5'd1);
        apb(1'b1, fa, 32'h1 << i);
        apb(1'b0, `USBIEF_OFF_RAW, 32'h0);
        chk(32'(q[b]), 32'h1);
        apb(1'b1, fa, 32'h1 << (i + 5'd1));
        apb(1'b0, `USBIEF_OFF_RAW, 32'h0);
        chk(32'(q[b]), 32'h0);
    endtask
    // Main sequence
    initial begin
        logic [19:0] en;
        logic [19:0] fo;
        q = $urandom(32'hb6b3aa7b);
        repeat (12) @(posedge clk_in);
        rst_in <= 1'b0;
        @(posedge clk_in);
        apb(1'b0, `USBIEF_OFF_ENABLE, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, `USBIEF_OFF_FORCE, 32'h0);
        chk(q, 32'h0);
        apb(1'b0, 12'h0fc, 32'h0);
        chk({q[30:0], e}, 32'h1);
        for (int k = 0; k < 6; k++) begin
            en = (k == 0) ? 20'h00000 : 20'($urandom);
            fo = (k == 0) ? 20'hfffff : 20'($urandom);
            apb(1'b1, `USBIEF_OFF_ENABLE, {12'hfff, en});
            apb(1'b1, `USBIEF_OFF_FORCE, {12'hfff, fo});
            apb(1'b0, `USBIEF_OFF_FORCE, 32'h0);
            chk(q, {12'h000, fo});
            apb(1'b0, `USBIEF_OFF_ENABLE, 32'h0);
            chk(q, {12'h000, en});
            apb(1'b0, `USBIEF_OFF_MASKED, 32'h0);
            chk(q, {12'h000, en & fo});
            chk(32'(irq), 32'(|(en & fo)));
        end
        apb(1'b1, `USBIEF_OFF_FORCE, 32'h0);
        apb(1'b1, `USBIEF_OFF_ENABLE, 32'hfffff);
        ev_chk(1'b0, 5'd0, 17, `USBIEF_OFF_FRAME_RD, 32'h0);
        ev_chk(1'b1, 5'd1, 2, `USBIEF_OFF_FRAME_RD, 32'h0);
        ev_chk(1'b0, 5'd2, 15, `USBIEF_OFF_ENG_STATUS, 32'h800);
        ev_chk(1'b1, 5'd2, 1, `USBIEF_OFF_ENG_STATUS, 32'h800);
        ev_chk(1'b0, 5'd3, 14, `USBIEF_OFF_ENG_STATUS, 32'h10);
        ev_chk(1'b0, 5'd4, 13, `USBIEF_OFF_ENG_STATUS, 32'h10000);
        ev_chk(1'b1, 5'd5, 0, `USBIEF_OFF_ENG_STATUS, 32'h3);
        ev_chk(1'b0, 5'd6, 3, `USBIEF_OFF_RAW, 32'h8);
        for (int k = 0; k < 8; k++) begin
            ev_chk(1'b0, 5'(7 + k), 5 + k, `USBIEF_OFF_ENG_STATUS, 32'h800000 << k);
        end
        ev_chk(1'b0, 5'd15, 16, `USBIEF_OFF_ENG_STATUS, 32'h80000000);
        ep_chk(5'd16, 19, `USBIEF_OFF_HALT_FLAGS);
        ep_chk(5'd17, 18, `USBIEF_OFF_ABORT_FLAGS);
        ep_chk(5'd18, 4, `USBIEF_OFF_BUF_FLAGS);
        apb(1'b0, `USBIEF_OFF_MASKED, 32'h0);
        chk(q, 32'h0);
        chk(32'(irq), 32'h0);
        apb(1'b1, `USBIEF_OFF_FORCE, 32'h10000);
        apb(1'b0, `USBIEF_OFF_MASKED, 32'h0);
        chk(q, 32'h10000);
        chk(32'(irq), 32'h1);
        apb(1'b1, `USBIEF_OFF_ENABLE, 32'h0);
        apb(1'b0, `USBIEF_OFF_MASKED, 32'h0);
        chk({q[30:0], irq}, 32'h0);
        results();
    end
endmodule // usbief_top_test
`default_nettype wire
